// file: rtl/wpm_wake_pin_monitor.sv
// Local wake input monitor: pin filter, wake requests toward the mode
// controller, direction event flags, interrupt and Wishbone registers.
// Assumes the mode code comes from logic on the same clock, while the
// pin and the undervoltage comparator are asynchronous.
//
// Chosen here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// (RULE1) Both a rising and a falling change of the wake input count as a wake event.
// (RULE2) A change counts only once the new level has persisted longer than the filter time.
// (RULE3) Software turns the wake capability on or off and the block obeys that setting in every mode but Fail-Safe.
// (RULE4) Below the undervoltage-off level all wake input activity is ignored; the code drops events but the level status follows the unfiltered pin.
// (RULE5) The filtered pin level is always readable in Normal, Stop and software flash modes.
// (RULE6) With the enable set, a qualified change of either direction wakes the chip from Sleep.
// (RULE7) From Fail-Safe, any qualified change always requests the move to Restart.
// (RULE8) With the enable set in Normal, Stop or flash mode, a change sets its direction flag and raises the interrupt unless masked.
// (RULE9) Rising and falling interrupts have independent mask bits.
// (RULE10) A flag pending or set during a sleep request makes the chip wake right after entering Sleep.
// (RULE11) The chip never settles in Sleep while a wake flag is uncleared.
// (RULE12) Software should clear both flags before commanding Sleep.
// (RULE13) Each flag stays set until software clears it by writing a one.
module wpm_wake_pin_monitor #(
    parameter int FILTER_CYCLES = wpm_pkg::WAKE_FILTER_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire wpm_pkg::wpm_wb_req_type wb_req,
    output wpm_pkg::wpm_wb_rsp_type wb_rsp,
    input wire logic local_wake_input,
    input wire logic below_undervoltage_off_level,
    input wire wpm_pkg::wpm_mode_type chip_mode,
    output logic wake_level_status,
    output logic wake_request,
    output logic sleep_veto,
    output logic irq
);

    // ********************************************************
    // Parameter check
    // ********************************************************
    if (FILTER_CYCLES < 1 || FILTER_CYCLES >= (1 << wpm_pkg::FILT_CNT_W))
    begin : g_bad_filter
        $error("FILTER_CYCLES out of range for the filter counter");
    end

    localparam logic [wpm_pkg::FILT_CNT_W-1:0] FILT_LAST =
        wpm_pkg::FILT_CNT_W'(FILTER_CYCLES - 1);

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        logic [2:0] pin_sync;
        logic pin_agreed;
        logic [2:0] uv_sync;
        logic uv_agreed;
        logic filt_level;
        logic [wpm_pkg::FILT_CNT_W-1:0] filt_cnt;
        logic enable;
        logic [1:0] flags;
        logic [1:0] mask;
        logic level_status;
        logic wake_req;
        logic veto;
        logic irq;
        logic ack;
        logic [31:0] rdat;
    } wpm_state_type;

    wpm_state_type s_q;
    wpm_state_type s_d;

    // Modes in which the pin is reported and flags are raised
    function automatic logic awake_mode(input wpm_pkg::wpm_mode_type m);
        awake_mode = (m == wpm_pkg::MODE_NORMAL) ||
                     (m == wpm_pkg::MODE_STOP) ||
                     (m == wpm_pkg::MODE_SOFTWARE_FLASH);
    endfunction

    // ********************************************************
    // Next state
    // ********************************************************
    logic rise_evt;
    logic fall_evt;
    logic any_evt;
    logic acc;
    logic wr_go;
    logic [1:0] set_bits;
    logic [1:0] clr_bits;
    logic [1:0] flags_next;

    always_comb begin
        s_d = s_q;

        // Three-stage synchronisers; a change counts once stages 2 and 3
        // agree, so a metastable first stage is never looked at.
        s_d.pin_sync = {s_q.pin_sync[1:0], local_wake_input};
        if (s_q.pin_sync[1] == s_q.pin_sync[2]) begin
            s_d.pin_agreed = s_q.pin_sync[2];
        end
        s_d.uv_sync = {s_q.uv_sync[1:0], below_undervoltage_off_level};
        if (s_q.uv_sync[1] == s_q.uv_sync[2]) begin
            s_d.uv_agreed = s_q.uv_sync[2];
        end

        // Glitch filter: the new level must hold for FILTER_CYCLES
        rise_evt = 1'b0;
        fall_evt = 1'b0;
        if (s_q.uv_agreed) begin
            // Track silently so recovery does not fire a stale event
            s_d.filt_level = s_q.pin_agreed; // RULE4
            s_d.filt_cnt = '0;
        end else if (s_q.pin_agreed == s_q.filt_level) begin
            s_d.filt_cnt = '0; // RULE2
        end else if (s_q.filt_cnt == FILT_LAST) begin
            s_d.filt_cnt = '0;
            s_d.filt_level = s_q.pin_agreed; // RULE2
            rise_evt = s_q.pin_agreed; // RULE1
            fall_evt = ~s_q.pin_agreed; // RULE1
        end else begin
            s_d.filt_cnt = s_q.filt_cnt + 1'b1;
        end
        any_evt = rise_evt | fall_evt;

        // Level is refreshed only while the chip is up
        if (awake_mode(chip_mode)) begin
            s_d.level_status = s_d.filt_level; // RULE5
        end

        // Wishbone: ack one cycle after the request is seen; a write
        // lands at the edge where the master samples ack.
        acc = wb_req.cyc & wb_req.stb;
        s_d.ack = acc & ~s_q.ack;
        wr_go = acc & wb_req.we & s_q.ack & wb_req.sel[0];
        if (acc & ~s_q.ack & ~wb_req.we) begin
            case (wb_req.adr)
                wpm_pkg::CTRL_ADR: begin
                    s_d.rdat = {31'h0, s_q.enable};
                end
                wpm_pkg::STATUS_ADR: begin
                    s_d.rdat = {29'h0, s_q.uv_agreed, s_q.veto,
                                s_q.level_status};
                end
                wpm_pkg::INT_STAT_ADR: begin
                    s_d.rdat = {30'h0, s_q.flags};
                end
                wpm_pkg::INT_MASK_ADR: begin
                    s_d.rdat = {30'h0, s_q.mask};
                end
                default: begin
                    s_d.rdat = 32'h0;
                end
            endcase
        end else if (~acc | s_q.ack) begin
            // Read data stands only in the ack cycle, zero otherwise
            s_d.rdat = 32'h0;
        end

        clr_bits = 2'h0;
        if (wr_go) begin
            case (wb_req.adr)
                wpm_pkg::CTRL_ADR: begin
                    s_d.enable = wb_req.dat[wpm_pkg::CTRL_ENABLE_BIT]; // RULE3
                end
                wpm_pkg::INT_STAT_ADR: begin
                    clr_bits = wb_req.dat[1:0]; // RULE13
                end
                wpm_pkg::INT_MASK_ADR: begin
                    s_d.mask = wb_req.dat[1:0]; // RULE9
                end
                default: begin
                end
            endcase
        end

        // Flags: a new event wins over a clear in the same cycle
        set_bits = 2'h0;
        if (s_q.enable && awake_mode(chip_mode)) begin // RULE3
            set_bits[wpm_pkg::FLAG_FIRST_BIT] = rise_evt; // RULE8
            set_bits[wpm_pkg::FLAG_SECOND_BIT] = fall_evt; // RULE8
        end
        flags_next = (s_q.flags & ~clr_bits) | set_bits; // RULE13
        s_d.flags = flags_next;
        s_d.irq = |(flags_next & ~s_q.mask); // RULE8 RULE9

        // Pending flags forbid a clean sleep and pull the chip out again
        s_d.veto = |flags_next; // RULE11
        s_d.wake_req = 1'b0;
        case (chip_mode)
            wpm_pkg::MODE_SLEEP: begin
                s_d.wake_req = (any_evt & s_q.enable) | // RULE6
                               (|s_q.flags); // RULE10 RULE11
            end
            wpm_pkg::MODE_FAIL_SAFE: begin
                s_d.wake_req = any_evt; // RULE7
            end
            default: begin
                s_d.wake_req = 1'b0;
            end
        endcase
    end

    // ********************************************************
    // Registers
    // ********************************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.enable <= wpm_pkg::CTRL_ENABLE_RST;
            s_q.mask <= wpm_pkg::INT_MASK_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_rsp.ack = s_q.ack;
    assign wb_rsp.dat = s_q.rdat;
    assign wake_level_status = s_q.level_status;
    assign wake_request = s_q.wake_req;
    assign sleep_veto = s_q.veto;
    assign irq = s_q.irq;

endmodule

`default_nettype wire

// file: rtl/wpm_pkg.sv
// Package for the local wake input monitor: register map, field
// positions, reset values, chip mode codes, timing and carrier types.
// Assumes a 100 MHz core clock and a 32-bit classic Wishbone slave.
package wpm_pkg;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int CLK_PERIOD_PS = 10000;
    // Least wake filter time; a level must persist this long
    localparam int WAKE_FILTER_TIME_NS = 10000;
    localparam int WAKE_FILTER_CYCLES =
        (WAKE_FILTER_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int FILT_CNT_W = 16;

    // ********************************************************
    // Register map (byte addresses)
    // ********************************************************
    localparam int ADR_W = 8;
    localparam logic [ADR_W-1:0] CTRL_ADR = 8'h00;
    localparam logic [ADR_W-1:0] STATUS_ADR = 8'h04;
    localparam logic [ADR_W-1:0] INT_STAT_ADR = 8'h08;
    localparam logic [ADR_W-1:0] INT_MASK_ADR = 8'h0c;

    // Field positions
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int STATUS_LEVEL_BIT = 0;
    localparam int STATUS_VETO_BIT = 1;
    localparam int STATUS_UV_BIT = 2;
    localparam int FLAG_FIRST_BIT = 0;
    localparam int FLAG_SECOND_BIT = 1;

    // Values after reset
    localparam logic CTRL_ENABLE_RST = 1'b0;
    localparam logic [1:0] INT_MASK_RST = 2'h0;

    // ********************************************************
    // Chip mode as driven by the mode controller
    // ********************************************************
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'b000,
        MODE_STOP = 3'b001,
        MODE_SLEEP = 3'b010,
        MODE_FAIL_SAFE = 3'b011,
        MODE_RESTART = 3'b100,
        MODE_SOFTWARE_FLASH = 3'b101,
        MODE_INIT = 3'b110
    } wpm_mode_type;

    // ********************************************************
    // Carriers
    // ********************************************************
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [ADR_W-1:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wpm_wb_req_type;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wpm_wb_rsp_type;

endpackage

// file: testbench/wpm_wake_pin_monitor_properties.sv
// Checker for the wake pin monitor, bound to the top module's ports.
// Assumes one clock domain with its asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module wpm_wake_pin_monitor_properties #(
    parameter int FILTER_CYCLES = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire wpm_pkg::wpm_wb_req_type wb_req,
    input wire wpm_pkg::wpm_wb_rsp_type wb_rsp,
    input wire logic local_wake_input,
    input wire logic below_undervoltage_off_level,
    input wire wpm_pkg::wpm_mode_type chip_mode,
    input wire logic wake_level_status,
    input wire logic wake_request,
    input wire logic sleep_veto,
    input wire logic irq
);
    // ********
    // Properties
    // ********
    logic clr_now;
    logic clr_q;
    assign clr_now = wb_rsp.ack && wb_req.we &&
        wb_req.adr == wpm_pkg::INT_STAT_ADR;
    // A flag may drop one edge after the clearing write lands
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clr_q <= 1'b0;
        end else begin
            clr_q <= clr_now;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_req_taken;
        $rose(wb_req.cyc && wb_req.stb);
    endsequence
    sequence s_flag_held;
        sleep_veto && !clr_now && !clr_q;
    endsequence
    property p_ack_answer;
        s_req_taken |=> wb_rsp.ack;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("ack late");
    property p_ack_pulse;
        wb_rsp.ack |=> !wb_rsp.ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_dat_idle;
        !wb_rsp.ack |-> wb_rsp.dat == 32'h0;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("data not idle");
    property p_flag_sticky;
        s_flag_held |=> sleep_veto;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");
    property p_irq_veto;
        irq |-> sleep_veto;
    endproperty
    a_irq_veto: assert property (p_irq_veto) else $error("irq no flag");
    property p_sleep_wake;
        (chip_mode == wpm_pkg::MODE_SLEEP && sleep_veto) [*3] |-> wake_request;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("no rewake");
    property p_uv_quiet;
        (below_undervoltage_off_level &&
            chip_mode == wpm_pkg::MODE_FAIL_SAFE) [*6] |-> !wake_request;
    endproperty
    a_uv_quiet: assert property (p_uv_quiet) else $error("wake under uv");
    property p_level_filter;
        $changed(wake_level_status) |->
            $past(local_wake_input, FILTER_CYCLES + 1) == wake_level_status &&
            $past(local_wake_input, FILTER_CYCLES + 2) == wake_level_status;
    endproperty
    a_level_filter: assert property (p_level_filter) else $error("unfiltered");
    property p_level_hold;
        (chip_mode == wpm_pkg::MODE_SLEEP) [*2] |-> $stable(wake_level_status);
    endproperty
    a_level_hold: assert property (p_level_hold) else $error("level moved");
endmodule
bind wpm_wake_pin_monitor wpm_wake_pin_monitor_properties #(
    .FILTER_CYCLES(FILTER_CYCLES)
) wpm_wake_pin_monitor_properties_i (
    .clock(clock), .rst(rst), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .local_wake_input(local_wake_input),
    .below_undervoltage_off_level(below_undervoltage_off_level),
    .chip_mode(chip_mode), .wake_level_status(wake_level_status),
    .wake_request(wake_request), .sleep_veto(sleep_veto), .irq(irq)
);
`default_nettype wire

// file: testbench/wpm_wake_source.sv
// External wake source: a switch line on the wake pin.
// Assumes calls are made just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module wpm_wake_source (
    input wire logic clock,
    output logic local_wake_input
);
    initial local_wake_input = 1'b0;
    // Short holds stand for spikes that the filter must swallow
    task automatic drive(input logic lvl, input int cycles);
        local_wake_input <= lvl;
        repeat (cycles) @(posedge clock);
    endtask
endmodule
`default_nettype wire

// file: testbench/tb.sv
// Testbench for the wake pin monitor: Wishbone tasks, directed tests.
// Assumes the package, design, wake source and checker are compiled.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
    localparam logic [7:0] ST = wpm_pkg::INT_STAT_ADR;
    localparam logic [7:0] SS = wpm_pkg::STATUS_ADR;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic uv = 1'b0;
    int wake_cnt = 0;
    int base = 0;
    logic pin, lvl, wreq, veto, irq;
    logic [31:0] r;
    int error_cnt = 0;
    int num_checks = 0;
    wpm_pkg::wpm_wb_req_type req = '0;
    wpm_pkg::wpm_wb_rsp_type rsp;
    wpm_pkg::wpm_mode_type mode = wpm_pkg::MODE_NORMAL;
    wpm_pkg::wpm_mode_type m[3] = '{wpm_pkg::MODE_NORMAL,
        wpm_pkg::MODE_STOP, wpm_pkg::MODE_SOFTWARE_FLASH};
    wpm_wake_source wpm_wake_source_i (.clock(clock), .local_wake_input(pin));
    wpm_wake_pin_monitor #(.FILTER_CYCLES(4)) wpm_wake_pin_monitor_i (
        .clock(clock), .rst(rst), .wb_req(req), .wb_rsp(rsp),
        .local_wake_input(pin), .below_undervoltage_off_level(uv),
        .chip_mode(mode), .wake_level_status(lvl), .wake_request(wreq),
        .sleep_veto(veto), .irq(irq));
    // ********
    // Tasks
    // ********
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req <= '{1'b1, 1'b1, w, a, 4'hf, d};
        do begin
            @(posedge clock);
            n++;
        end while (rsp.ack !== 1'b1 && n < 50);
        r = rsp.dat;
        req <= '0;
        if (n >= 50) error_cnt++;
        repeat (2) @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        `CHK(r, e)
    endtask
    task automatic end_sim();
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ********
    // Tests
    // ********
    initial forever #5 clock = ~clock;
    always @(posedge clock) if (wreq === 1'b1) wake_cnt <= wake_cnt + 1;
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        end_sim();
    end
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(wpm_pkg::CTRL_ADR, 32'h0);
        rd(wpm_pkg::INT_MASK_ADR, 32'h0);
        rd(8'h10, 32'h0);
        wb(1'b1, wpm_pkg::CTRL_ADR, 32'h1);
        wpm_wake_source_i.drive(1'b1, 2);
        wpm_wake_source_i.drive(1'b0, 20);
        rd(ST, 32'h0);
        for (int i = 0; i < 3; i++) begin
            mode <= m[i];
            wb(1'b1, ST, 32'h3);
            wpm_wake_source_i.drive(1'b1, 20);
            rd(ST, 32'h1);
            rd(SS, 32'h3);
            `CHK(lvl, 1'b1)
            `CHK(veto, 1'b1)
            wpm_wake_source_i.drive(1'b0, 20);
            rd(ST, 32'h3);
        end
        wb(1'b1, wpm_pkg::INT_MASK_ADR, 32'h1);
        `CHK(irq, 1'b1)
        wb(1'b1, wpm_pkg::INT_MASK_ADR, 32'h3);
        `CHK(irq, 1'b0)
        wb(1'b1, ST, 32'h1);
        rd(ST, 32'h2);
        wb(1'b1, wpm_pkg::INT_MASK_ADR, 32'h1);
        `CHK(irq, 1'b1)
        mode <= wpm_pkg::MODE_SLEEP;
        repeat (4) @(posedge clock);
        `CHK(wreq, 1'b1)
        wb(1'b1, ST, 32'h3);
        wb(1'b1, wpm_pkg::CTRL_ADR, 32'h0);
        base = wake_cnt;
        wpm_wake_source_i.drive(1'b1, 20);
        `CHK(wake_cnt != base, 1'b0)
        wb(1'b1, wpm_pkg::CTRL_ADR, 32'h1);
        base = wake_cnt;
        wpm_wake_source_i.drive(1'b0, 20);
        `CHK(wake_cnt != base, 1'b1)
        wb(1'b1, wpm_pkg::CTRL_ADR, 32'h0);
        mode <= wpm_pkg::MODE_FAIL_SAFE;
        base = wake_cnt;
        wpm_wake_source_i.drive(1'b1, 20);
        `CHK(wake_cnt != base, 1'b1)
        uv <= 1'b1;
        base = wake_cnt;
        wpm_wake_source_i.drive(1'b0, 20);
        `CHK(wake_cnt != base, 1'b0)
        rd(SS, 32'h4);
        `CHK(lvl, 1'b0)
        end_sim();
    end
endmodule
`default_nettype wire
